//--- rtl/eaad_pkg.sv
// package: register map, field layout, thresholds and carriers of the e1 ais alarm detector
package eaad_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [5:0] IDX_BLOCK_IRQ_EN    = 6'h01;
	localparam logic [5:0] IDX_ALARM_STATUS    = 6'h02;
	localparam logic [5:0] IDX_ALARM_IRQ_EN    = 6'h03;
	localparam logic [5:0] IDX_CLEAR_MODE      = 6'h05;
	localparam logic [5:0] IDX_ALARM_GEN_CTRL  = 6'h08;

	// ==========================================================
	// field positions
	localparam int BIT_BLOCK_ALARM_EN  = 1;  // block-level alarm/error enable
	localparam int BIT_AIS_STATE       = 6;  // read-only ais state
	localparam int BIT_AIS16_STATE     = 5;  // read-only ais16 state
	localparam int BIT_AIS_CHANGE      = 1;  // ais state change, sticky
	localparam int BIT_AIS16_CHANGE    = 0;  // ais16 state change, sticky
	localparam int BIT_READ_CLEARS     = 0;  // reset-upon-read select
	localparam int SEL_LO              = 0;  // detection select field, bits 1-0

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_BLOCK_IRQ_EN   = 8'h00;
	localparam logic [7:0] RST_ALARM_IRQ_EN   = 8'h00;
	localparam logic [7:0] RST_CLEAR_MODE     = 8'h00;
	localparam logic [7:0] RST_ALARM_GEN_CTRL = 8'h00;

	// ==========================================================
	// detection and integration figures
	localparam logic [1:0] ZERO_LIMIT      = 2'h3;   // fewer zeros than this per frame pair
	localparam logic [4:0] DET_PER_INT     = 5'h10;  // sixteen possible detections
	localparam logic [4:0] DET_VALID_MIN   = 5'h0D;  // thirteen detections make a valid flag
	localparam logic [4:0] AIS_DECLARE     = 5'h19;  // 25 valid flags
	localparam logic [4:0] AIS16_DECLARE   = 5'h16;  // 22 valid flags
	localparam logic [4:0] LAST_SLOT       = 5'h1F;
	localparam logic [4:0] SIGNAL_SLOT     = 5'h10;
	localparam int         INTERVAL_US     = 4000;   // 4 ms integration interval
	localparam int         CLK_PERIOD_NS   = 100;
	localparam int         INTERVAL_CYCLES = (INTERVAL_US * 1000) / CLK_PERIOD_NS;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		SEL_OFF       = 2'h0,
		SEL_UNFRAMED  = 2'h1,
		SEL_AIS16     = 2'h2,
		SEL_FRAMED    = 2'h3
	} eaad_sel_t;

	typedef struct packed {
		logic       valid;  // one byte of the receive stream this cycle
		logic [4:0] slot;   // time slot number of the byte
		logic [7:0] data;   // received byte
	} eaad_rx_byte_t;

endpackage

//--- rtl/eaad_top.sv
// e1 receive ais / ais16 alarm detector with apb register slave
`timescale 1ns/1ns
// ==========================================================
// Operation
// (R1) detection: under three zeros per frame pair
// (R2) framed mode skips time slot 0
// (R3) thirteen of sixteen detections per interval valid
// (R4) valid flags count up, declare at 25
// (R5) invalid interval counts down, clear at zero
// (R6) ais16: two ts16 all-ones, multiframe lost
// (R7) ais16 flags count up, declare at 22
// (R8) no ais16 flag counts down, clear zero
// (R9) select bits 1-0 choose detection type
// (R10) ais change raises interrupt when enabled
// (R11) per-source enable bit 1 gates ais
// (R12) block enable bit 1 gates all alarms
// (R13) status bit 6 shows ais state
// (R14) status bit 1 set on ais change
// (R15) read clears if selected, else write-clear
// (R16) change bit held until cleared by status read or write
// (R17) flag counters saturate at threshold and zero
module eaad_top #(
	parameter int INTERVAL_LEN = eaad_pkg::INTERVAL_CYCLES
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rstn,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic [7:0]             paddr,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// receive line side
	input  wire eaad_pkg::eaad_rx_byte_t rx_byte,
	input  wire logic                   cas_mf_lost,
	// alarm outputs
	output logic                        ais_alarm,
	output logic                        ais16_alarm,
	output logic                        irq
);

	// elaboration check: the interval counter is 20 bits wide
	if (INTERVAL_LEN < 2 || INTERVAL_LEN > 1048576) begin : g_bad_interval
		$error("eaad_top: INTERVAL_LEN out of range");
	end

	// ==========================================================
	// helpers

	// number of zero bits in a byte
	function automatic logic [3:0] zeros_in(input logic [7:0] b);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, ~b[i]};
		end
		return n;
	endfunction

	// up/down flag counter, held at both ends
	function automatic logic [4:0] flag_step(input logic [4:0] c, input logic up,
			input logic [4:0] top);
		if (up) begin
			return (c >= top) ? top : c + 5'h01;  // [R17]
		end
		return (c == 5'h00) ? 5'h00 : c - 5'h01;  // [R17]
	endfunction

	// ==========================================================
	// registers
	logic [7:0]  block_irq_en_q;
	logic [7:0]  alarm_irq_en_q;
	logic [7:0]  clear_mode_q;
	logic [7:0]  alarm_gen_ctrl_q;
	logic        ais_chg_q;
	logic        ais16_chg_q;
	logic        ais_state_q;
	logic        ais16_state_q;
	logic [1:0]  pair_zeros_q;
	logic        pair_half_q;
	logic        ts16_ones_q;
	logic [4:0]  ais_det_q;
	logic [4:0]  ais16_det_q;
	logic [4:0]  ais_flags_q;
	logic [4:0]  ais16_flags_q;
	logic [19:0] tick_cnt_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        irq_q;

	eaad_pkg::eaad_sel_t sel;
	logic        access;
	logic        wr_now;
	logic        rd_now;
	logic [5:0]  idx;
	logic        addr_ok;
	logic        tick;
	logic        frame_end;
	logic        byte_counts;
	logic [3:0]  byte_zeros;
	logic [4:0]  zero_sum;
	logic        ais_det_hit;
	logic        ais16_det_hit;
	logic [4:0]  ais_flags_d;
	logic [4:0]  ais16_flags_d;
	logic        ais_state_d;
	logic        ais16_state_d;
	logic        ais_mode;

	// ==========================================================
	// apb decode: one wait state, request taken while pready_q is clear
	assign access  = psel & penable & ~pready_q;
	assign idx     = paddr[7:2];
	assign addr_ok = (paddr[1:0] == 2'h0) &&
		(idx == eaad_pkg::IDX_BLOCK_IRQ_EN || idx == eaad_pkg::IDX_ALARM_STATUS ||
		 idx == eaad_pkg::IDX_ALARM_IRQ_EN || idx == eaad_pkg::IDX_CLEAR_MODE ||
		 idx == eaad_pkg::IDX_ALARM_GEN_CTRL);
	assign wr_now  = access & pwrite & addr_ok;
	assign rd_now  = access & ~pwrite & addr_ok;
	assign sel     = eaad_pkg::eaad_sel_t'(alarm_gen_ctrl_q[eaad_pkg::SEL_LO +: 2]);
	assign ais_mode = (sel == eaad_pkg::SEL_UNFRAMED) || (sel == eaad_pkg::SEL_FRAMED);

	// bus handshake and error answer
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= access;
			pslverr_q <= access & ~addr_ok;
		end
	end

	// read data, captured on the access edge
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prdata_q <= 32'h0000_0000;
		end else if (access) begin
			prdata_q <= 32'h0000_0000;
			if (!pwrite) begin
				unique case (idx)
					eaad_pkg::IDX_BLOCK_IRQ_EN:   prdata_q[7:0] <= block_irq_en_q;
					eaad_pkg::IDX_ALARM_IRQ_EN:   prdata_q[7:0] <= alarm_irq_en_q;
					eaad_pkg::IDX_CLEAR_MODE:     prdata_q[7:0] <= clear_mode_q;
					eaad_pkg::IDX_ALARM_GEN_CTRL: prdata_q[7:0] <= alarm_gen_ctrl_q;
					eaad_pkg::IDX_ALARM_STATUS: begin
						prdata_q[eaad_pkg::BIT_AIS_STATE]    <= ais_state_q;    // [R13]
						prdata_q[eaad_pkg::BIT_AIS16_STATE]  <= ais16_state_q;
						prdata_q[eaad_pkg::BIT_AIS_CHANGE]   <= ais_chg_q;
						prdata_q[eaad_pkg::BIT_AIS16_CHANGE] <= ais16_chg_q;
					end
					default: prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// per-register write strobes, taken on the access edge
	logic        wr_block_en;
	logic        wr_alarm_en;
	logic        wr_clear_mode;
	logic        wr_gen_ctrl;
	assign wr_block_en   = wr_now && (idx == eaad_pkg::IDX_BLOCK_IRQ_EN);
	assign wr_alarm_en   = wr_now && (idx == eaad_pkg::IDX_ALARM_IRQ_EN);
	assign wr_clear_mode = wr_now && (idx == eaad_pkg::IDX_CLEAR_MODE);
	assign wr_gen_ctrl   = wr_now && (idx == eaad_pkg::IDX_ALARM_GEN_CTRL);

	// block-level alarm interrupt enable
	always_ff @(posedge clk) begin
		if (!rstn) begin
			block_irq_en_q <= eaad_pkg::RST_BLOCK_IRQ_EN;
		end else if (wr_block_en) begin
			block_irq_en_q <= pwdata[7:0];  // [R12]
		end
	end

	// per-source alarm interrupt enables
	always_ff @(posedge clk) begin
		if (!rstn) begin
			alarm_irq_en_q <= eaad_pkg::RST_ALARM_IRQ_EN;
		end else if (wr_alarm_en) begin
			alarm_irq_en_q <= pwdata[7:0];  // [R11]
		end
	end

	// change-bit clear mode select
	always_ff @(posedge clk) begin
		if (!rstn) begin
			clear_mode_q <= eaad_pkg::RST_CLEAR_MODE;
		end else if (wr_clear_mode) begin
			clear_mode_q <= pwdata[7:0];  // [R15]
		end
	end

	// detection select and the rest of the control byte
	always_ff @(posedge clk) begin
		if (!rstn) begin
			alarm_gen_ctrl_q <= eaad_pkg::RST_ALARM_GEN_CTRL;
		end else if (wr_gen_ctrl) begin
			alarm_gen_ctrl_q <= pwdata[7:0];  // [R9]
		end
	end

	// ==========================================================
	// interval timer: one tick every 4 ms
	assign tick = (tick_cnt_q == 20'(INTERVAL_LEN - 1));

	always_ff @(posedge clk) begin
		if (!rstn) begin
			tick_cnt_q <= 20'h00000;
		end else if (tick) begin
			tick_cnt_q <= 20'h00000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 20'h00001;
		end
	end

	// ==========================================================
	// frame-pair zero counting for ais detection
	assign frame_end   = rx_byte.valid && (rx_byte.slot == eaad_pkg::LAST_SLOT);
	assign byte_counts = rx_byte.valid &&
		!(sel == eaad_pkg::SEL_FRAMED && rx_byte.slot == 5'h00);  // [R2]
	assign byte_zeros  = byte_counts ? zeros_in(rx_byte.data) : 4'h0;
	assign zero_sum    = {3'h0, pair_zeros_q} + {1'h0, byte_zeros};
	assign ais_det_hit = frame_end && pair_half_q && ais_mode &&
		(zero_sum < {3'h0, eaad_pkg::ZERO_LIMIT});  // [R1]

	// running zero count, saturating at the limit, reset every second frame
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pair_zeros_q <= 2'h0;
			pair_half_q  <= 1'b0;
		end else if (rx_byte.valid) begin
			if (frame_end && pair_half_q) begin
				pair_zeros_q <= 2'h0;  // [R1]
			end else if (zero_sum >= {3'h0, eaad_pkg::ZERO_LIMIT}) begin
				pair_zeros_q <= eaad_pkg::ZERO_LIMIT;
			end else begin
				pair_zeros_q <= zero_sum[1:0];
			end
			if (frame_end) begin
				pair_half_q <= ~pair_half_q;
			end
		end
	end

	// ==========================================================
	// ais16 detection: consecutive all-ones slot 16 bytes while multiframe lost
	assign ais16_det_hit = rx_byte.valid && (rx_byte.slot == eaad_pkg::SIGNAL_SLOT) &&
		(sel == eaad_pkg::SEL_AIS16) && cas_mf_lost &&
		(rx_byte.data == 8'hFF) && ts16_ones_q;  // [R6]

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ts16_ones_q <= 1'b0;
		end else if (rx_byte.valid && rx_byte.slot == eaad_pkg::SIGNAL_SLOT) begin
			ts16_ones_q <= (rx_byte.data == 8'hFF);
		end
	end

	// ==========================================================
	// detection counters per interval
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ais_det_q <= 5'h00;
		end else if (tick) begin
			ais_det_q <= 5'h00;
		end else if (ais_det_hit && ais_det_q < eaad_pkg::DET_PER_INT) begin
			ais_det_q <= ais_det_q + 5'h01;  // [R3]
		end
	end

	// ais16 detections in the same interval
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ais16_det_q <= 5'h00;
		end else if (tick) begin
			ais16_det_q <= 5'h00;
		end else if (ais16_det_hit && ais16_det_q < eaad_pkg::DET_PER_INT) begin
			ais16_det_q <= ais16_det_q + 5'h01;  // [R7]
		end
	end

	// ==========================================================
	// flag integration and alarm state
	assign ais_flags_d = flag_step(ais_flags_q, ais_det_q >= eaad_pkg::DET_VALID_MIN,
		eaad_pkg::AIS_DECLARE);  // [R3] [R4] [R5]
	assign ais16_flags_d = flag_step(ais16_flags_q, ais16_det_q != 5'h00,
		eaad_pkg::AIS16_DECLARE);  // [R7] [R8]
	assign ais_state_d = (ais_flags_d == eaad_pkg::AIS_DECLARE) ? 1'b1 :
		(ais_flags_d == 5'h00) ? 1'b0 : ais_state_q;  // [R4] [R5]
	assign ais16_state_d = (ais16_flags_d == eaad_pkg::AIS16_DECLARE) ? 1'b1 :
		(ais16_flags_d == 5'h00) ? 1'b0 : ais16_state_q;  // [R7] [R8]

	// ais flag counter and state, stepped on each tick
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ais_flags_q <= 5'h00;
			ais_state_q <= 1'b0;
		end else if (tick) begin
			ais_flags_q <= ais_flags_d;  // [R4] [R5]
			ais_state_q <= ais_state_d;
		end
	end

	// ais16 flag counter and state, stepped on each tick
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ais16_flags_q <= 5'h00;
			ais16_state_q <= 1'b0;
		end else if (tick) begin
			ais16_flags_q <= ais16_flags_d;  // [R7] [R8]
			ais16_state_q <= ais16_state_d;
		end
	end

	// ==========================================================
	// sticky change bits: set wins over read-clear and write-one-clear
	logic status_hit;
	logic rd_clear;
	logic ais_set;
	logic ais16_set;
	assign status_hit = idx == eaad_pkg::IDX_ALARM_STATUS;
	assign rd_clear   = rd_now && status_hit && clear_mode_q[eaad_pkg::BIT_READ_CLEARS];
	assign ais_set    = tick && (ais_state_d != ais_state_q);      // [R14]
	assign ais16_set  = tick && (ais16_state_d != ais16_state_q);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ais_chg_q <= 1'b0;
		end else if (ais_set) begin
			ais_chg_q <= 1'b1;  // [R14]
		end else if (rd_clear ||
				(wr_now && status_hit && pwdata[eaad_pkg::BIT_AIS_CHANGE])) begin
			ais_chg_q <= 1'b0;  // [R15] [R16]
		end
	end

	// ais16 change bit, same clearing rules
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ais16_chg_q <= 1'b0;
		end else if (ais16_set) begin
			ais16_chg_q <= 1'b1;
		end else if (rd_clear ||
				(wr_now && status_hit && pwdata[eaad_pkg::BIT_AIS16_CHANGE])) begin
			ais16_chg_q <= 1'b0;  // [R15]
		end
	end

	// ==========================================================
	// interrupt: per-source enable and block enable
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= block_irq_en_q[eaad_pkg::BIT_BLOCK_ALARM_EN] &&       // [R12]
				((ais_chg_q && alarm_irq_en_q[eaad_pkg::BIT_AIS_CHANGE]) ||  // [R10] [R11]
				 (ais16_chg_q && alarm_irq_en_q[eaad_pkg::BIT_AIS16_CHANGE]));
		end
	end

	// ==========================================================
	// outputs
	assign prdata      = prdata_q;
	assign pready      = pready_q;
	assign pslverr     = pslverr_q;
	assign ais_alarm   = ais_state_q;
	assign ais16_alarm = ais16_state_q;
	assign irq         = irq_q;

endmodule // eaad_top

//--- tb/eaad_top_monitor.sv
// checker: apb timing, interrupt gating and alarm dwell of the ais detector
`timescale 1ns/1ns
module eaad_top_monitor #(
	parameter int INTERVAL_LEN = 40000
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// alarms
	input wire logic        ais_alarm,
	input wire logic        ais16_alarm,
	input wire logic        irq
);
	// ==========================================================
	// helper logic
	logic        blk_q;
	logic        en_q;
	int unsigned ais_age_q;
	int unsigned a16_age_q;
	wire logic   acc = psel && penable && !pready;

	// shadow of the enable bits, taken at the access edge
	always_ff @(posedge clk) begin
		if (!rstn) begin
			blk_q <= 1'b0;
			en_q  <= 1'b0;
		end else if (acc && pwrite) begin
			if (paddr == 8'h04) blk_q <= pwdata[1];
			if (paddr == 8'h0C) en_q <= pwdata[1];
		end
	end

	// cycles since each alarm last changed
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ais_age_q <= 0;
			a16_age_q <= 0;
		end else begin
			ais_age_q <= $changed(ais_alarm) ? 0 : ais_age_q + 1;
			a16_age_q <= $changed(ais16_alarm) ? 0 : a16_age_q + 1;
		end
	end

	// ==========================================================
	// assertions
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	a_ready_one_wait: assert property (acc |=> pready)
		else $error("pready missing after access edge");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_unmapped: assert property (acc && !(paddr inside {8'h04, 8'h08, 8'h0C, 8'h14,
		8'h20}) |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_irq_gated: assert property (!blk_q |=> !irq)
		else $error("irq while block enable off");
	a_irq_on_change: assert property ($rose(ais_alarm) && blk_q && en_q && !psel
		|-> ##[0:2] irq)
		else $error("no irq on ais change");
	a_ais_dwell: assert property ($changed(ais_alarm) |-> ais_age_q >= 24 * INTERVAL_LEN)
		else $error("ais alarm changed too soon");
	a_ais16_dwell: assert property ($changed(ais16_alarm)
		|-> a16_age_q >= 21 * INTERVAL_LEN)
		else $error("ais16 alarm changed too soon");
endmodule // eaad_top_monitor

bind eaad_top eaad_top_monitor #(.INTERVAL_LEN(INTERVAL_LEN)) u_mon (.clk(clk), .rstn(rstn),
	.psel(psel), .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .ais_alarm(ais_alarm),
	.ais16_alarm(ais16_alarm), .irq(irq));

//--- tb/eaad_line_model.sv
// line model: remote e1 terminal sending one byte per clock
`timescale 1ns/1ns
module eaad_line_model (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rstn,
	// slot contents chosen by the bench
	input  wire logic [7:0]         ts0_byte,
	input  wire logic [7:0]         ts16_byte,
	// stream toward the detector
	output eaad_pkg::eaad_rx_byte_t rx_byte
);
	logic [4:0] slot_q;

	// slot counter; slot 31 closes each frame
	always_ff @(posedge clk) begin
		if (!rstn) begin
			slot_q <= 5'h00;
		end else begin
			slot_q <= slot_q + 5'h01;
		end
	end

	// payload all ones, slots 0 and 16 as the bench asks
	always_comb begin
		rx_byte.valid = rstn;
		rx_byte.slot  = slot_q;
		rx_byte.data  = (slot_q == 5'h00) ? ts0_byte : (slot_q == 5'h10) ? ts16_byte : 8'hFF;
	end
endmodule // eaad_line_model

//--- tb/eaad_top_tb_top.sv
// testbench: register access and alarm scenarios of the ais detector
`timescale 1ns/1ns
module eaad_top_tb_top;
	localparam int L = 1000;
	logic                    clk, rstn, psel, penable, pwrite, pready, pslverr, err_q;
	logic                    cas_mf_lost, ais_alarm, ais16_alarm, irq;
	logic [7:0]              paddr, ts0_byte, ts16_byte;
	logic [31:0]             pwdata, prdata, rd_q;
	logic [7:0]              regs [5] = '{8'h04, 8'h08, 8'h0C, 8'h14, 8'h20};
	eaad_pkg::eaad_rx_byte_t rx_byte;
	int                      error_cnt = 0;
	int                      n_compared = 0;

	// ==========================================================
	// design and line model
	eaad_top #(.INTERVAL_LEN(L)) dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_byte(rx_byte), .cas_mf_lost(cas_mf_lost),
		.ais_alarm(ais_alarm), .ais16_alarm(ais16_alarm), .irq(irq));
	eaad_line_model u_line (.clk(clk), .rstn(rstn), .ts0_byte(ts0_byte),
		.ts16_byte(ts16_byte), .rx_byte(rx_byte));

	// ==========================================================
	// tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer, held until pready at a rising edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd_q    = prdata;
		err_q   = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(a, 1'b0, 32'h0);
		chk(what, exp, rd_q);
	endtask

	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==========================================================
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		results();
	end

	// ==========================================================
	// scenarios
	initial begin
		{rstn, psel, penable, pwrite, cas_mf_lost} = 5'h00;
		{paddr, pwdata} = 40'h0;
		ts0_byte  = 8'h1B;
		ts16_byte = 8'hFF;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		foreach (regs[i]) rd(regs[i], 32'h0, "reset value");
		apb(8'h10, 1'b0, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err_q});
		// framed ais with framing zeros in slot 0
		apb(8'h20, 1'b1, 32'h3);
		rd(8'h20, 32'h3, "detect select");
		apb(8'h04, 1'b1, 32'h2);
		apb(8'h0C, 1'b1, 32'h2);
		repeat (L * 47 / 2) @(posedge clk);
		chk("ais early", 32'h0, {31'h0, ais_alarm});
		repeat (3 * L) @(posedge clk);
		chk("ais declared", 32'h1, {31'h0, ais_alarm});
		chk("irq on ais", 32'h1, {31'h0, irq});
		rd(8'h08, 32'h42, "status declared");
		apb(8'h08, 1'b1, 32'h2);
		rd(8'h08, 32'h40, "status write cleared");
		chk("irq cleared", 32'h0, {31'h0, irq});
		// unframed: four zeros per pair in slot 0, no detection
		ts0_byte <= 8'hFC;
		apb(8'h20, 1'b1, 32'h1);
		apb(8'h0C, 1'b1, 32'h1);
		repeat (L * 47 / 2) @(posedge clk);
		chk("ais held", 32'h1, {31'h0, ais_alarm});
		repeat (3 * L) @(posedge clk);
		chk("ais removed", 32'h0, {31'h0, ais_alarm});
		chk("irq per-source off", 32'h0, {31'h0, irq});
		apb(8'h14, 1'b1, 32'h1);
		rd(8'h08, 32'h02, "change kept");
		rd(8'h08, 32'h00, "read cleared");
		// ais16: multiframe loss raised two intervals after the select
		apb(8'h0C, 1'b1, 32'h1);
		apb(8'h04, 1'b1, 32'h2);
		apb(8'h20, 1'b1, 32'h2);
		repeat (2 * L) @(posedge clk);
		cas_mf_lost <= 1'b1;
		repeat (L * 41 / 2) @(posedge clk);
		chk("ais16 early", 32'h0, {31'h0, ais16_alarm});
		repeat (3 * L) @(posedge clk);
		chk("ais16 declared", 32'h1, {31'h0, ais16_alarm});
		chk("irq on ais16", 32'h1, {31'h0, irq});
		apb(8'h04, 1'b1, 32'h0);
		@(posedge clk);
		chk("irq block enable off", 32'h0, {31'h0, irq});
		rd(8'h08, 32'h21, "ais16 status");
		rd(8'h08, 32'h20, "ais16 read cleared");
		results();
	end
endmodule // eaad_top_tb_top
